// *** otsr_regs.sv ***
// otsr_regs.sv: oscillator trim registers and analog health status,
// reached over a plain address / strobe register port.
// assumes: one clock, synchronous inputs on the bus side, status
// levels from the analog side may change at any time.
`timescale 1ns/1ps
`default_nettype none

`include "otsr_cfg.svh"

module otsr_regs (
  // clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // register port
  input  wire logic [31:0]           addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic      [15:0]           rdata,
  // power state
  input  wire logic                  sleep_active,
  output logic                       sleep_blocked,
  // analog controls and status
  output otsr_pkg::otsr_ctrl_t       ana_ctrl,
  input  wire otsr_pkg::otsr_status_t ana_status
);

  localparam int STW = $bits(otsr_pkg::otsr_status_t);

  // stored settings and their next values
  otsr_pkg::otsr_ctrl_t   ctrl_q;
  otsr_pkg::otsr_ctrl_t   ctrl_d;
  // analog control drive
  otsr_pkg::otsr_ctrl_t   ana_q;
  otsr_pkg::otsr_ctrl_t   ana_d;
  logic                   blk_q;
  logic                   blk_d;
  // read path
  logic [15:0]            rdata_q;
  logic [15:0]            rdata_d;
  // synchronised status
  logic [STW-1:0]         st_sync;
  otsr_pkg::otsr_status_t st;
  otsr_pkg::otsr_sel_t    sel;

  // address decode, shared by write and read paths
  function automatic otsr_pkg::otsr_sel_t dec(input logic [31:0] a);
    otsr_pkg::otsr_sel_t s;
    s = otsr_pkg::OTSR_SEL_NONE;
    unique case (a)
      `OTSR_LF_RC_OFS:   s = otsr_pkg::OTSR_SEL_LF_RC;
      `OTSR_LF_XO_OFS:   s = otsr_pkg::OTSR_SEL_LF_XO;
      `OTSR_HF_RC_OFS:   s = otsr_pkg::OTSR_SEL_HF_RC;
      `OTSR_SLOW_RC_OFS: s = otsr_pkg::OTSR_SEL_SLOW_RC;
      `OTSR_REF_OFS:     s = otsr_pkg::OTSR_SEL_REF;
      `OTSR_STATUS_OFS:  s = otsr_pkg::OTSR_SEL_STATUS;
      default:           s = otsr_pkg::OTSR_SEL_NONE;
    endcase
    return s;
  endfunction

  // coarse range codes 2 and 3 give the same drive
  function automatic logic [1:0] range_fold(input logic [1:0] r);
    return (r > `OTSR_HFRC_RNG_TOP) ? `OTSR_HFRC_RNG_TOP : r;
  endfunction

  // current register selection
  assign sel = dec(addr);

  // two-flop crossing of every analog status level
  otsr_sync #(
    .W (STW)
  ) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .ce      (ce),
    .async_i (ana_status),
    .sync_o  (st_sync)
  );

  // synchronised levels seen as named flags
  assign st = otsr_pkg::otsr_status_t'(st_sync);

  // next values of the settings on a write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_stb) begin
      unique case (sel)
        // lf rc trim and off
        otsr_pkg::OTSR_SEL_LF_RC: begin
          ctrl_d.lf_rc.lf_rc_trim =
            wdata[`OTSR_LFRC_TRIM_MSB:`OTSR_LFRC_TRIM_LSB];
          ctrl_d.lf_rc.lf_rc_off = wdata[`OTSR_LFRC_OFF_BIT];
        end

        // crystal amplitude, bias and enable
        otsr_pkg::OTSR_SEL_LF_XO: begin
          ctrl_d.lf_xo.lf_xo_amp_reg_off =
            wdata[`OTSR_LFXO_AMP_BIT];
          ctrl_d.lf_xo.lf_xo_bias_current =
            wdata[`OTSR_LFXO_CUR_MSB:`OTSR_LFXO_CUR_LSB];
          ctrl_d.lf_xo.lf_xo_bias_resistor =
            wdata[`OTSR_LFXO_RES_MSB:`OTSR_LFXO_RES_LSB];
          ctrl_d.lf_xo.lf_xo_on = wdata[`OTSR_LFXO_ON_BIT];
        end

        // hf rc capacitance, range, bias and off
        otsr_pkg::OTSR_SEL_HF_RC: begin
          ctrl_d.hf_rc.hf_rc_cap_adjust =
            wdata[`OTSR_HFRC_CAP_MSB:`OTSR_HFRC_CAP_LSB];
          ctrl_d.hf_rc.hf_rc_coarse_range =
            wdata[`OTSR_HFRC_RNG_MSB:`OTSR_HFRC_RNG_LSB];
          ctrl_d.hf_rc.hf_rc_bias =
            wdata[`OTSR_HFRC_BIAS_MSB:`OTSR_HFRC_BIAS_LSB];
          ctrl_d.hf_rc.hf_rc_off = wdata[`OTSR_HFRC_OFF_BIT];
        end

        // slow rc bias, capacitance, resistance, enable
        otsr_pkg::OTSR_SEL_SLOW_RC: begin
          ctrl_d.slow_rc.slow_rc_bias =
            wdata[`OTSR_SRC_BIAS_MSB:`OTSR_SRC_BIAS_LSB];
          ctrl_d.slow_rc.slow_rc_unit_cap =
            wdata[`OTSR_SRC_C0_BIT];
          ctrl_d.slow_rc.slow_rc_cap_adjust =
            wdata[`OTSR_SRC_CAP_MSB:`OTSR_SRC_CAP_LSB];
          ctrl_d.slow_rc.slow_rc_res_select =
            wdata[`OTSR_SRC_RES_BIT];
          ctrl_d.slow_rc.slow_rc_on = wdata[`OTSR_SRC_ON_BIT];
        end

        // reference current and voltage trims
        otsr_pkg::OTSR_SEL_REF: begin
          ctrl_d.refc.ref_current_trim =
            wdata[`OTSR_REF_CUR_MSB:`OTSR_REF_CUR_LSB];
          ctrl_d.refc.ref_voltage_trim =
            wdata[`OTSR_REF_VOLT_MSB:`OTSR_REF_VOLT_LSB];
        end

        // status and unmapped addresses take no write
        otsr_pkg::OTSR_SEL_STATUS: ctrl_d = ctrl_q;
        otsr_pkg::OTSR_SEL_NONE:   ctrl_d = ctrl_q;
      endcase
    end
  end

  // analog drive follows the next settings, so a write acts at once
  always_comb begin
    ana_d = ctrl_d;
    ana_d.hf_rc.hf_rc_coarse_range =
      range_fold(ctrl_d.hf_rc.hf_rc_coarse_range);
    // hardware switches the hf rc off for as long as sleep lasts
    ana_d.hf_rc.hf_rc_off = ctrl_d.hf_rc.hf_rc_off | sleep_active;
  end

  // lf rc off withholds permission to sleep
  always_comb begin
    blk_d = ctrl_d.lf_rc.lf_rc_off;
  end

  // read word for the addressed register, zero where reserved
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_stb) begin
      unique case (sel)
        // lf rc word
        otsr_pkg::OTSR_SEL_LF_RC: begin
          rdata_d[`OTSR_LFRC_TRIM_MSB:`OTSR_LFRC_TRIM_LSB] =
            ctrl_q.lf_rc.lf_rc_trim;
          rdata_d[`OTSR_LFRC_OFF_BIT] = ctrl_q.lf_rc.lf_rc_off;
        end

        // crystal word, bits 15:8 reserved
        otsr_pkg::OTSR_SEL_LF_XO: begin
          rdata_d[`OTSR_LFXO_AMP_BIT] = ctrl_q.lf_xo.lf_xo_amp_reg_off;
          rdata_d[`OTSR_LFXO_CUR_MSB:`OTSR_LFXO_CUR_LSB] =
            ctrl_q.lf_xo.lf_xo_bias_current;
          rdata_d[`OTSR_LFXO_RES_MSB:`OTSR_LFXO_RES_LSB] =
            ctrl_q.lf_xo.lf_xo_bias_resistor;
          rdata_d[`OTSR_LFXO_ON_BIT] = ctrl_q.lf_xo.lf_xo_on;
        end

        // hf rc word
        otsr_pkg::OTSR_SEL_HF_RC: begin
          rdata_d[`OTSR_HFRC_CAP_MSB:`OTSR_HFRC_CAP_LSB] =
            ctrl_q.hf_rc.hf_rc_cap_adjust;
          rdata_d[`OTSR_HFRC_RNG_MSB:`OTSR_HFRC_RNG_LSB] =
            ctrl_q.hf_rc.hf_rc_coarse_range; // stored code, unfolded
          rdata_d[`OTSR_HFRC_BIAS_MSB:`OTSR_HFRC_BIAS_LSB] =
            ctrl_q.hf_rc.hf_rc_bias;
          rdata_d[`OTSR_HFRC_OFF_BIT] = ctrl_q.hf_rc.hf_rc_off;
        end

        // slow rc word
        otsr_pkg::OTSR_SEL_SLOW_RC: begin
          rdata_d[`OTSR_SRC_BIAS_MSB:`OTSR_SRC_BIAS_LSB] =
            ctrl_q.slow_rc.slow_rc_bias;
          rdata_d[`OTSR_SRC_C0_BIT] = ctrl_q.slow_rc.slow_rc_unit_cap;
          rdata_d[`OTSR_SRC_CAP_MSB:`OTSR_SRC_CAP_LSB] =
            ctrl_q.slow_rc.slow_rc_cap_adjust;
          rdata_d[`OTSR_SRC_RES_BIT] = ctrl_q.slow_rc.slow_rc_res_select;
          rdata_d[`OTSR_SRC_ON_BIT] = ctrl_q.slow_rc.slow_rc_on;
        end

        // reference word
        otsr_pkg::OTSR_SEL_REF: begin
          rdata_d[`OTSR_REF_CUR_MSB:`OTSR_REF_CUR_LSB] =
            ctrl_q.refc.ref_current_trim;
          rdata_d[`OTSR_REF_VOLT_MSB:`OTSR_REF_VOLT_LSB] =
            ctrl_q.refc.ref_voltage_trim;
        end

        // health levels after the synchroniser
        otsr_pkg::OTSR_SEL_STATUS: begin
          rdata_d[`OTSR_ST_WAKE_BIT] = st.wake_tree_level;
          rdata_d[`OTSR_ST_CONV_BIT] = st.conv_reg_good;
          rdata_d[`OTSR_ST_XOREG_BIT] = st.xo_reg_good;
          rdata_d[`OTSR_ST_BOOST_BIT] = st.boost_detected;
          rdata_d[`OTSR_ST_VBH_BIT] = st.vbat_high_good;
          rdata_d[`OTSR_ST_VBL_BIT] = st.vbat_low_good;
          rdata_d[`OTSR_ST_REF_BIT] = st.ref_good;
          rdata_d[`OTSR_ST_HBELOW_BIT] = st.vbat_high_below;
          rdata_d[`OTSR_ST_HABOVE_BIT] = st.vbat_high_above;
          rdata_d[`OTSR_ST_DCDC_BIT] = st.converter_good;
          rdata_d[`OTSR_ST_LOWREG_BIT] = st.low_reg_good;
          rdata_d[`OTSR_ST_CORE_BIT] = st.core_reg_good;
        end

        // unmapped addresses read as zero
        otsr_pkg::OTSR_SEL_NONE: rdata_d = 16'h0000;
      endcase
    end
  end

  // register the stored settings
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // low-frequency rc
      ctrl_q.lf_rc.lf_rc_trim           <= `OTSR_LFRC_TRIM_RST;
      ctrl_q.lf_rc.lf_rc_off            <= `OTSR_LFRC_OFF_RST;

      // low-frequency crystal
      ctrl_q.lf_xo.lf_xo_amp_reg_off    <= `OTSR_LFXO_AMP_RST;
      ctrl_q.lf_xo.lf_xo_bias_current   <= `OTSR_LFXO_CUR_RST;
      ctrl_q.lf_xo.lf_xo_bias_resistor  <= `OTSR_LFXO_RES_RST;
      ctrl_q.lf_xo.lf_xo_on             <= `OTSR_LFXO_ON_RST;

      // high-frequency rc
      ctrl_q.hf_rc.hf_rc_cap_adjust     <= `OTSR_HFRC_CAP_RST;
      ctrl_q.hf_rc.hf_rc_coarse_range   <= `OTSR_HFRC_RNG_RST;
      ctrl_q.hf_rc.hf_rc_bias           <= `OTSR_HFRC_BIAS_RST;
      ctrl_q.hf_rc.hf_rc_off            <= `OTSR_HFRC_OFF_RST;

      // slow rc
      ctrl_q.slow_rc.slow_rc_bias       <= `OTSR_SRC_BIAS_RST;
      ctrl_q.slow_rc.slow_rc_unit_cap   <= `OTSR_SRC_C0_RST;
      ctrl_q.slow_rc.slow_rc_cap_adjust <= `OTSR_SRC_CAP_RST;
      ctrl_q.slow_rc.slow_rc_res_select <= `OTSR_SRC_RES_RST;
      ctrl_q.slow_rc.slow_rc_on         <= `OTSR_SRC_ON_RST;

      // reference
      ctrl_q.refc.ref_current_trim      <= `OTSR_REF_CUR_RST;
      ctrl_q.refc.ref_voltage_trim      <= `OTSR_REF_VOLT_RST;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // register the analog drive, from the same defaults
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // low-frequency rc
      ana_q.lf_rc.lf_rc_trim            <= `OTSR_LFRC_TRIM_RST;
      ana_q.lf_rc.lf_rc_off             <= `OTSR_LFRC_OFF_RST;

      // low-frequency crystal
      ana_q.lf_xo.lf_xo_amp_reg_off     <= `OTSR_LFXO_AMP_RST;
      ana_q.lf_xo.lf_xo_bias_current    <= `OTSR_LFXO_CUR_RST;
      ana_q.lf_xo.lf_xo_bias_resistor   <= `OTSR_LFXO_RES_RST;
      ana_q.lf_xo.lf_xo_on              <= `OTSR_LFXO_ON_RST;

      // high-frequency rc
      ana_q.hf_rc.hf_rc_cap_adjust      <= `OTSR_HFRC_CAP_RST;
      ana_q.hf_rc.hf_rc_coarse_range    <= `OTSR_HFRC_RNG_RST;
      ana_q.hf_rc.hf_rc_bias            <= `OTSR_HFRC_BIAS_RST;
      ana_q.hf_rc.hf_rc_off             <= `OTSR_HFRC_OFF_RST;

      // slow rc
      ana_q.slow_rc.slow_rc_bias        <= `OTSR_SRC_BIAS_RST;
      ana_q.slow_rc.slow_rc_unit_cap    <= `OTSR_SRC_C0_RST;
      ana_q.slow_rc.slow_rc_cap_adjust  <= `OTSR_SRC_CAP_RST;
      ana_q.slow_rc.slow_rc_res_select  <= `OTSR_SRC_RES_RST;
      ana_q.slow_rc.slow_rc_on          <= `OTSR_SRC_ON_RST;

      // reference
      ana_q.refc.ref_current_trim       <= `OTSR_REF_CUR_RST;
      ana_q.refc.ref_voltage_trim       <= `OTSR_REF_VOLT_RST;
    end else if (ce) begin
      ana_q <= ana_d;
    end
  end

  // register the sleep permission
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      blk_q <= `OTSR_LFRC_OFF_RST;
    end else if (ce) begin
      blk_q <= blk_d;
    end
  end

  // register read data, zero outside the answer cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign ana_ctrl      = ana_q;
  assign sleep_blocked = blk_q;
  assign rdata         = rdata_q;

endmodule

`default_nettype wire

// *** otsr_cfg.svh ***
// otsr_cfg.svh: offsets, field positions and reset values of the
// oscillator trim and analog status register bank.
// assumes: included by bare name; definitions only.
`ifndef OTSR_CFG_SVH
`define OTSR_CFG_SVH

// register addresses as seen on the register port
`define OTSR_LF_RC_OFS     32'h5000_0020
`define OTSR_LF_XO_OFS     32'h5000_0022
`define OTSR_HF_RC_OFS     32'h5000_0024
`define OTSR_SLOW_RC_OFS   32'h5000_0026
`define OTSR_REF_OFS       32'h5000_0028
`define OTSR_STATUS_OFS    32'h5000_002a

// low-frequency rc oscillator control
`define OTSR_LFRC_TRIM_MSB 4
`define OTSR_LFRC_TRIM_LSB 1
`define OTSR_LFRC_OFF_BIT  0
`define OTSR_LFRC_TRIM_RST 4'h7
`define OTSR_LFRC_OFF_RST  1'h0

// low-frequency crystal oscillator control
`define OTSR_LFXO_AMP_BIT  7
`define OTSR_LFXO_CUR_MSB  6
`define OTSR_LFXO_CUR_LSB  3
`define OTSR_LFXO_RES_MSB  2
`define OTSR_LFXO_RES_LSB  1
`define OTSR_LFXO_ON_BIT   0
`define OTSR_LFXO_AMP_RST  1'h0
`define OTSR_LFXO_CUR_RST  4'h5
`define OTSR_LFXO_RES_RST  2'h3
`define OTSR_LFXO_ON_RST   1'h0

// high-frequency rc oscillator control
`define OTSR_HFRC_CAP_MSB  10
`define OTSR_HFRC_CAP_LSB  7
`define OTSR_HFRC_RNG_MSB  6
`define OTSR_HFRC_RNG_LSB  5
`define OTSR_HFRC_BIAS_MSB 4
`define OTSR_HFRC_BIAS_LSB 1
`define OTSR_HFRC_OFF_BIT  0
`define OTSR_HFRC_CAP_RST  4'hf
`define OTSR_HFRC_RNG_RST  2'h0
`define OTSR_HFRC_BIAS_RST 4'h7
`define OTSR_HFRC_OFF_RST  1'h0
`define OTSR_HFRC_RNG_TOP  2'h2

// slow rc oscillator control
`define OTSR_SRC_BIAS_MSB  11
`define OTSR_SRC_BIAS_LSB  8
`define OTSR_SRC_C0_BIT    7
`define OTSR_SRC_CAP_MSB   6
`define OTSR_SRC_CAP_LSB   2
`define OTSR_SRC_RES_BIT   1
`define OTSR_SRC_ON_BIT    0
`define OTSR_SRC_BIAS_RST  4'ha
`define OTSR_SRC_C0_RST    1'h1
`define OTSR_SRC_CAP_RST   5'h1f
`define OTSR_SRC_RES_RST   1'h0
`define OTSR_SRC_ON_RST    1'h0

// reference trim
`define OTSR_REF_CUR_MSB   9
`define OTSR_REF_CUR_LSB   5
`define OTSR_REF_VOLT_MSB  4
`define OTSR_REF_VOLT_LSB  0
`define OTSR_REF_CUR_RST   5'h00
`define OTSR_REF_VOLT_RST  5'h00

// analog health status bit positions
`define OTSR_ST_WAKE_BIT   12
`define OTSR_ST_CONV_BIT   10
`define OTSR_ST_XOREG_BIT  9
`define OTSR_ST_BOOST_BIT  8
`define OTSR_ST_VBH_BIT    7
`define OTSR_ST_VBL_BIT    6
`define OTSR_ST_REF_BIT    5
`define OTSR_ST_HBELOW_BIT 4
`define OTSR_ST_HABOVE_BIT 3
`define OTSR_ST_DCDC_BIT   2
`define OTSR_ST_LOWREG_BIT 1
`define OTSR_ST_CORE_BIT   0

`endif

// *** otsr_pkg.sv ***
// otsr_pkg.sv: types of the oscillator trim and analog status bank.
// assumes: field widths match the positions in otsr_cfg.svh.
package otsr_pkg;

  typedef struct packed {
    logic [3:0] lf_rc_trim;
    logic       lf_rc_off;
  } otsr_lf_rc_t;

  typedef struct packed {
    logic       lf_xo_amp_reg_off;
    logic [3:0] lf_xo_bias_current;
    logic [1:0] lf_xo_bias_resistor;
    logic       lf_xo_on;
  } otsr_lf_xo_t;

  typedef struct packed {
    logic [3:0] hf_rc_cap_adjust;
    logic [1:0] hf_rc_coarse_range;
    logic [3:0] hf_rc_bias;
    logic       hf_rc_off;
  } otsr_hf_rc_t;

  typedef struct packed {
    logic [3:0] slow_rc_bias;
    logic       slow_rc_unit_cap;
    logic [4:0] slow_rc_cap_adjust;
    logic       slow_rc_res_select;
    logic       slow_rc_on;
  } otsr_slow_rc_t;

  typedef struct packed {
    logic [4:0] ref_current_trim;
    logic [4:0] ref_voltage_trim;
  } otsr_ref_t;

  // all software-held settings, also the analog control bundle
  typedef struct packed {
    otsr_lf_rc_t   lf_rc;
    otsr_lf_xo_t   lf_xo;
    otsr_hf_rc_t   hf_rc;
    otsr_slow_rc_t slow_rc;
    otsr_ref_t     refc;
  } otsr_ctrl_t;

  // raw health levels from the analog domain
  typedef struct packed {
    logic wake_tree_level;
    logic conv_reg_good;
    logic xo_reg_good;
    logic boost_detected;
    logic vbat_high_good;
    logic vbat_low_good;
    logic ref_good;
    logic vbat_high_below;
    logic vbat_high_above;
    logic converter_good;
    logic low_reg_good;
    logic core_reg_good;
  } otsr_status_t;

  // register selected by an address
  typedef enum logic [2:0] {
    OTSR_SEL_NONE,
    OTSR_SEL_LF_RC,
    OTSR_SEL_LF_XO,
    OTSR_SEL_HF_RC,
    OTSR_SEL_SLOW_RC,
    OTSR_SEL_REF,
    OTSR_SEL_STATUS
  } otsr_sel_t;

endpackage

// *** otsr_sync.sv ***
// otsr_sync.sv: two-flop synchroniser for a vector of levels.
// assumes: each bit is an independent level; clock enable freezes it.
`timescale 1ns/1ps
`default_nettype none

module otsr_sync #(
  parameter int W = 12
) (
  // clock and control
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // each bit passes through its own pair of flops
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        meta_d[i] = async_i[i];
        sync_d[i] = meta_q[i]; // only the second stage reads the first
      end
    end
  endgenerate

  // register both stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

// *** otsr_regs_assertions.sv ***
// otsr_regs_assertions.sv: port checks of the oscillator trim bank.
// assumes: bound to otsr_regs; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "otsr_cfg.svh"
module otsr_regs_chk (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   ce,
  // register port
  input wire logic [31:0]            addr,
  input wire logic [15:0]            wdata,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [15:0]            rdata,
  // power and analog side
  input wire logic                   sleep_active,
  input wire logic                   sleep_blocked,
  input wire otsr_pkg::otsr_ctrl_t   ana_ctrl,
  input wire otsr_pkg::otsr_status_t ana_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // accepted write to one address
  sequence s_wr(logic [31:0] a);
    ce && wr_stb && addr == a;
  endsequence
  // status levels settled long enough to cross the synchroniser
  sequence s_quiet;
    (ce && $stable(ana_status)) [*3];
  endsequence
  property p_rdata_idle; ce && !rd_stb |=> rdata == 16'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_lf_rc; s_wr(`OTSR_LF_RC_OFS) |=> ana_ctrl.lf_rc == $past(wdata[4:0])
    && sleep_blocked == $past(wdata[0]); endproperty
  a_lf_rc: assert property (p_lf_rc) else $error("lf rc drive wrong");
  property p_lf_xo; s_wr(`OTSR_LF_XO_OFS) |=> ana_ctrl.lf_xo == $past(wdata[7:0]); endproperty
  a_lf_xo: assert property (p_lf_xo) else $error("crystal drive wrong");
  property p_hf_rc; s_wr(`OTSR_HF_RC_OFS) |=> ana_ctrl.hf_rc.hf_rc_coarse_range ==
    ($past(wdata[6:5]) == 2'h3 ? 2'h2 : $past(wdata[6:5]))
    && ana_ctrl.hf_rc.hf_rc_cap_adjust == $past(wdata[10:7]); endproperty
  a_hf_rc: assert property (p_hf_rc) else $error("hf rc drive wrong");
  property p_slow; s_wr(`OTSR_SLOW_RC_OFS) |=> ana_ctrl.slow_rc == $past(wdata[11:0]); endproperty
  a_slow: assert property (p_slow) else $error("slow rc drive wrong");
  property p_ref; s_wr(`OTSR_REF_OFS) |=> ana_ctrl.refc == $past(wdata[9:0]); endproperty
  a_ref: assert property (p_ref) else $error("reference drive wrong");
  property p_sleep_off; ce && sleep_active |=> ana_ctrl.hf_rc.hf_rc_off; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("hf rc not off in sleep");
  property p_status; s_quiet ##0 (rd_stb && addr == `OTSR_STATUS_OFS) |=> rdata ==
    {3'h0, $past(ana_status[11]), 1'b0, $past(ana_status[10:0])}; endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  property p_st_nowr; s_wr(`OTSR_STATUS_OFS) ##0 $stable(sleep_active) |=> $stable(ana_ctrl);
  endproperty
  a_st_nowr: assert property (p_st_nowr) else $error("status write had effect");
  property p_freeze; !ce |=> $stable(rdata) && $stable(ana_ctrl); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved without enable");
endmodule
bind otsr_regs otsr_regs_chk chk_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sleep_active(sleep_active),
  .sleep_blocked(sleep_blocked), .ana_ctrl(ana_ctrl), .ana_status(ana_status));
`default_nettype wire

// *** otsr_regs_tb.sv ***
// otsr_regs_tb.sv: self-checking bench for the oscillator trim bank.
// assumes: register port with one-cycle read latency, 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "otsr_cfg.svh"
module otsr_regs_tb;
  logic                   mclk, rst_n, ce, wr_stb, rd_stb, sleep_active, sleep_blocked;
  logic [31:0]            addr;
  logic [15:0]            wdata, rdata, d, e;
  otsr_pkg::otsr_ctrl_t   ana_ctrl;
  otsr_pkg::otsr_status_t ana_status;
  logic [15:0]            img [5];
  logic [31:0]            adr [5] = '{`OTSR_LF_RC_OFS, `OTSR_LF_XO_OFS, `OTSR_HF_RC_OFS,
                                      `OTSR_SLOW_RC_OFS, `OTSR_REF_OFS};
  logic [15:0]            msk [5] = '{16'h001f, 16'h00ff, 16'h07ff, 16'h0fff, 16'h03ff};
  logic [15:0]            rst [5] = '{16'h000e, 16'h002e, 16'h078e, 16'h0afc, 16'h0000};
  logic [15:0]            pat [4] = '{16'hffff, 16'h5555, 16'haaaa, 16'h0000};
  int                     error_cnt, n_checks;
  otsr_regs dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sleep_active(sleep_active),
    .sleep_blocked(sleep_blocked), .ana_ctrl(ana_ctrl), .ana_status(ana_status));
  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle write, one-cycle read with data the cycle after
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr <= a; wdata <= v; wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  task automatic put(input int i, input logic [15:0] v);
    wr(adr[i], v);
    img[i] = v & msk[i];
  endtask
  // expected analog drive: range 3 folds to 2, sleep forces hf off
  function automatic otsr_pkg::otsr_ctrl_t exp_ctrl(input logic s);
    logic [15:0] h;
    h = img[2];
    if (h[6:5] == 2'h3) h[6:5] = 2'h2;
    h[0] = h[0] | s;
    return {img[0][4:0], img[1][7:0], h[10:0], img[3][11:0], img[4][9:0]};
  endfunction
  task automatic verify(input logic s);
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], v);
      check("readback", 64'(v), 64'(img[i]));
    end
    check("ana_ctrl", 64'(ana_ctrl), 64'(exp_ctrl(s)));
    check("sleep_blocked", 64'(sleep_blocked), 64'(img[0][0]));
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    rst_n = 1'b0; ce = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; sleep_active = 1'b0;
    addr = 32'h0; wdata = 16'h0; ana_status = '0; img = rst;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    verify(1'b0);
    // every register at all-ones, alternating and zero, each xor its index; ranges 3, 2, 1, 0
    foreach (pat[p]) begin
      for (int i = 0; i < 5; i++) put(i, pat[p] ^ 16'(i));
      verify(1'b0);
    end
    // status and unmapped writes ignored, unmapped read zero
    wr(`OTSR_STATUS_OFS, 16'hffff);
    wr(32'h5000_002c, 16'hffff);
    wr(32'h4000_0020, 16'hffff);
    rd(32'h5000_002c, d);
    check("unmapped", 64'(d), 64'h0);
    verify(1'b0);
    // walking one then all ones on the health levels; a read issued right
    // after a change still sees the old levels through the two flops
    e = 16'h0000;
    for (int b = 0; b < 13; b++) begin
      @(posedge mclk);
      ana_status <= (b == 12) ? 12'hfff : 12'(1 << b);
      rd(`OTSR_STATUS_OFS, d);
      check("status_old", 64'(d), 64'(e));
      rd(`OTSR_STATUS_OFS, d);
      e = {3'h0, ana_status[11], 1'b0, ana_status[10:0]};
      check("status", 64'(d), 64'(e));
    end
    // sleep forces hf off without changing the stored bit; lf off blocks sleep
    put(0, 16'h0001);
    sleep_active <= 1'b1;
    verify(1'b1);
    @(posedge mclk);
    sleep_active <= 1'b0;
    verify(1'b0);
    // back-to-back write then read
    @(posedge mclk);
    addr <= adr[3]; wdata <= 16'h0583; wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0; rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    check("b2b", 64'(rdata), 64'h0583);
    img[3] = 16'h0583;
    // disabled clock enable ignores strobes
    @(posedge mclk);
    ce <= 1'b0;
    wr(adr[4], 16'h0210);
    ce <= 1'b1;
    verify(1'b0);
    // reset in mid-run restores defaults
    put(2, 16'h0060);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    img = rst;
    verify(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
